// file: core/cb_regs.sv
// control, mode and input-select registers of the second analog comparator
`timescale 1ns/1ns
`default_nettype none
module cb_regs (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_pkg48,
  input  wire logic       i_cmp_out,
  output logic            o_cmp_b_enable,
  output logic      [1:0] o_pos_hyst_sel,
  output logic      [1:0] o_neg_hyst_sel,
  output logic      [2:0] o_inverting_pin_sel,
  output logic      [2:0] o_noninverting_pin_sel,
  output logic      [5:0] o_inverting_pin,
  output logic            o_inverting_pin_valid,
  output logic      [5:0] o_noninverting_pin,
  output logic            o_noninverting_pin_valid,
  output logic      [1:0] o_response_mode_sel,
  output logic            o_cmp_irq
);

  logic       wr_ctl;
  logic       wr_mode;
  logic       wr_sel;
  logic       cmp_sync;
  logic       cmp_prev_ff;
  logic       rise_edge;
  logic       fall_edge;
  logic       cmp_b_enable_ff;
  logic [1:0] pos_hyst_sel_ff;
  logic [1:0] neg_hyst_sel_ff;
  logic       rise_edge_flag_ff;
  logic       fall_edge_flag_ff;
  logic       nxt_rise_flag;
  logic       nxt_fall_flag;
  logic [7:0] cmp_b_input_select_reg_ff;
  logic [7:0] cmp_b_mode_reg_ff;
  logic [7:0] cmp_b_control_reg;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  assign wr_ctl  = i_sfr_wr && (i_sfr_addr == cb_pkg::ADDR_CONTROL);
  assign wr_mode = i_sfr_wr && (i_sfr_addr == cb_pkg::ADDR_MODE);
  assign wr_sel  = i_sfr_wr && (i_sfr_addr == cb_pkg::ADDR_INPUT_SEL);

  cb_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async (i_cmp_out),
    .o_sync  (cmp_sync)
  );

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmp_prev_ff <= 1'b0;
    end else begin
      cmp_prev_ff <= cmp_sync;
    end
  end

  // a disabled comparator's output is meaningless, so its edges are not flagged
  assign rise_edge = cmp_b_enable_ff && cmp_sync && !cmp_prev_ff;
  assign fall_edge = cmp_b_enable_ff && !cmp_sync && cmp_prev_ff;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmp_b_enable_ff <= cb_pkg::RST_CONTROL[cb_pkg::CTL_ENABLE_BIT];
      pos_hyst_sel_ff <= cb_pkg::RST_CONTROL[cb_pkg::CTL_POS_HYST_LSB +: cb_pkg::HYST_W];
      neg_hyst_sel_ff <= cb_pkg::RST_CONTROL[cb_pkg::CTL_NEG_HYST_LSB +: cb_pkg::HYST_W];
    end else if (wr_ctl) begin
      cmp_b_enable_ff <= i_sfr_wdata[cb_pkg::CTL_ENABLE_BIT];
      pos_hyst_sel_ff <= i_sfr_wdata[cb_pkg::CTL_POS_HYST_LSB +: cb_pkg::HYST_W];
      neg_hyst_sel_ff <= i_sfr_wdata[cb_pkg::CTL_NEG_HYST_LSB +: cb_pkg::HYST_W];
    end
  end

  // hardware edge wins over a same-cycle software write
  always_comb begin
    nxt_rise_flag = rise_edge_flag_ff;
    nxt_fall_flag = fall_edge_flag_ff;
    if (wr_ctl) begin
      nxt_rise_flag = i_sfr_wdata[cb_pkg::CTL_RISE_FLAG_BIT];
      nxt_fall_flag = i_sfr_wdata[cb_pkg::CTL_FALL_FLAG_BIT];
    end
    if (rise_edge) begin
      nxt_rise_flag = 1'b1;
    end
    if (fall_edge) begin
      nxt_fall_flag = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rise_edge_flag_ff <= cb_pkg::RST_CONTROL[cb_pkg::CTL_RISE_FLAG_BIT];
      fall_edge_flag_ff <= cb_pkg::RST_CONTROL[cb_pkg::CTL_FALL_FLAG_BIT];
    end else begin
      rise_edge_flag_ff <= nxt_rise_flag;
      fall_edge_flag_ff <= nxt_fall_flag;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmp_b_input_select_reg_ff <= cb_pkg::RST_INPUT_SEL;
    end else if (wr_sel) begin
      cmp_b_input_select_reg_ff <= i_sfr_wdata & cb_pkg::MASK_INPUT_SEL;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cmp_b_mode_reg_ff <= cb_pkg::RST_MODE;
    end else if (wr_mode) begin
      cmp_b_mode_reg_ff <= i_sfr_wdata & cb_pkg::MASK_MODE;
    end
  end

  cb_pin_decode #(
    .IS_NEG (1'b1)
  ) u_neg_decode (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_pkg48     (i_pkg48),
    .i_code      (cmp_b_input_select_reg_ff[cb_pkg::SEL_NEG_LSB +: cb_pkg::SEL_W]),
    .o_pin       (o_inverting_pin),
    .o_pin_valid (o_inverting_pin_valid)
  );

  cb_pin_decode #(
    .IS_NEG (1'b0)
  ) u_pos_decode (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_pkg48     (i_pkg48),
    .i_code      (cmp_b_input_select_reg_ff[cb_pkg::SEL_POS_LSB +: cb_pkg::SEL_W]),
    .o_pin       (o_noninverting_pin),
    .o_pin_valid (o_noninverting_pin_valid)
  );

  // result bit is the synchronised output, read-only
  always_comb begin
    cmp_b_control_reg = 8'h00;
    cmp_b_control_reg[cb_pkg::CTL_ENABLE_BIT] = cmp_b_enable_ff;
    cmp_b_control_reg[cb_pkg::CTL_RESULT_BIT] = cmp_sync;
    cmp_b_control_reg[cb_pkg::CTL_RISE_FLAG_BIT] = rise_edge_flag_ff;
    cmp_b_control_reg[cb_pkg::CTL_FALL_FLAG_BIT] = fall_edge_flag_ff;
    cmp_b_control_reg[cb_pkg::CTL_POS_HYST_LSB +: cb_pkg::HYST_W] = pos_hyst_sel_ff;
    cmp_b_control_reg[cb_pkg::CTL_NEG_HYST_LSB +: cb_pkg::HYST_W] = neg_hyst_sel_ff;
  end

  // unmapped addresses read zero
  always_comb begin
    unique case (i_sfr_addr)
      cb_pkg::ADDR_CONTROL:   nxt_rdata = cmp_b_control_reg;
      cb_pkg::ADDR_MODE:      nxt_rdata = cmp_b_mode_reg_ff;
      cb_pkg::ADDR_INPUT_SEL: nxt_rdata = cmp_b_input_select_reg_ff;
      default:                nxt_rdata = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata_ff <= 8'h00;
    end else if (i_sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_sfr_rdata            = rdata_ff;
  assign o_cmp_b_enable         = cmp_b_enable_ff;
  assign o_pos_hyst_sel         = pos_hyst_sel_ff;
  assign o_neg_hyst_sel         = neg_hyst_sel_ff;
  assign o_inverting_pin_sel    = cmp_b_input_select_reg_ff[cb_pkg::SEL_NEG_LSB +: cb_pkg::SEL_W];
  assign o_noninverting_pin_sel = cmp_b_input_select_reg_ff[cb_pkg::SEL_POS_LSB +: cb_pkg::SEL_W];
  assign o_response_mode_sel    = cmp_b_mode_reg_ff[cb_pkg::MODE_RESP_LSB +: cb_pkg::RESP_W];
  assign o_cmp_irq = (rise_edge_flag_ff && cmp_b_mode_reg_ff[cb_pkg::MODE_RISE_IE_BIT])
                  || (fall_edge_flag_ff && cmp_b_mode_reg_ff[cb_pkg::MODE_FALL_IE_BIT]);

endmodule
`default_nettype wire

// file: core/cb_pkg.sv
// constants, register map and pin tables for the second comparator's control logic
package cb_pkg;

  // special-function-register addresses
  localparam logic [7:0] ADDR_CONTROL    = 8'h9A;
  localparam logic [7:0] ADDR_MODE       = 8'h9C;
  localparam logic [7:0] ADDR_INPUT_SEL  = 8'h9E;

  // reset values
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_MODE        = 8'h02;
  localparam logic [7:0] RST_INPUT_SEL   = 8'h00;

  // control register fields
  localparam int CTL_ENABLE_BIT          = 7;
  localparam int CTL_RESULT_BIT          = 6;
  localparam int CTL_RISE_FLAG_BIT       = 5;
  localparam int CTL_FALL_FLAG_BIT       = 4;
  localparam int CTL_POS_HYST_LSB        = 2;
  localparam int CTL_NEG_HYST_LSB        = 0;
  localparam int HYST_W                  = 2;

  // mode register fields
  localparam int MODE_RISE_IE_BIT        = 5;
  localparam int MODE_FALL_IE_BIT        = 4;
  localparam int MODE_RESP_LSB           = 0;
  localparam int RESP_W                  = 2;

  // input select register fields
  localparam int SEL_NEG_LSB             = 4;
  localparam int SEL_POS_LSB             = 0;
  localparam int SEL_W                   = 3;

  // writable-bit masks; unused bits read zero and ignore writes
  localparam logic [7:0] MASK_INPUT_SEL  = 8'h77;
  localparam logic [7:0] MASK_MODE       = 8'h33;

  // highest legal pin select code
  localparam logic [2:0] SEL_MAX_CODE    = 3'h4;

  // pin encoding is {port[2:0], bit[2:0]}
  localparam int PIN_W                   = 6;

  // one decode shared by both input multiplexers and both package options
  function automatic logic [5:0] cb_pin_map(input logic is_neg, input logic pkg48, input logic [2:0] code);
    logic [5:0] pin;
    pin = 6'h00;
    unique case ({is_neg, pkg48, code})
      5'b1_0_000: pin = 6'h0B;
      5'b1_0_001: pin = 6'h0F;
      5'b1_0_010: pin = 6'h13;
      5'b1_0_011: pin = 6'h17;
      5'b1_0_100: pin = 6'h05;
      5'b1_1_000: pin = 6'h13;
      5'b1_1_001: pin = 6'h19;
      5'b1_1_010: pin = 6'h20;
      5'b1_1_011: pin = 6'h26;
      5'b1_1_100: pin = 6'h0A;
      5'b0_0_000: pin = 6'h0A;
      5'b0_0_001: pin = 6'h0E;
      5'b0_0_010: pin = 6'h12;
      5'b0_0_011: pin = 6'h16;
      5'b0_0_100: pin = 6'h04;
      5'b0_1_000: pin = 6'h12;
      5'b0_1_001: pin = 6'h18;
      5'b0_1_010: pin = 6'h1F;
      5'b0_1_011: pin = 6'h25;
      5'b0_1_100: pin = 6'h09;
      default:    pin = 6'h00;
    endcase
    return pin;
  endfunction

endpackage

// file: core/cb_sync.sv
// two-flop synchroniser for the comparator's analog output
`timescale 1ns/1ns
`default_nettype none
module cb_sync (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule
`default_nettype wire

// file: core/cb_pin_decode.sv
// registered decode of an input-select code to a port pin number
`timescale 1ns/1ns
`default_nettype none
module cb_pin_decode #(
  parameter bit IS_NEG = 1'b0
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_pkg48,
  input  wire logic [2:0] i_code,
  output logic      [5:0] o_pin,
  output logic            o_pin_valid
);
  logic [5:0] pin_ff;
  logic       valid_ff;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pin_ff   <= 6'h00;
      valid_ff <= 1'b0;
    end else begin
      pin_ff   <= cb_pkg::cb_pin_map(IS_NEG, i_pkg48, i_code);
      // codes above the table route no pin
      valid_ff <= (i_code <= cb_pkg::SEL_MAX_CODE);
    end
  end

  assign o_pin       = pin_ff;
  assign o_pin_valid = valid_ff;
endmodule
`default_nettype wire

// file: test/cb_cmp_model.sv
// behavioural analog comparator core seen by the control logic
`timescale 1ns/1ns
`default_nettype none
module cb_cmp_model (
  input  wire logic i_enable,
  input  wire logic i_level,
  output logic      o_cmp_out
);
  // a powered-down core drives low, so enabling while high makes a real edge
  assign o_cmp_out = i_enable & i_level;
endmodule
`default_nettype wire

// file: test/cb_regs_checker.sv
// port assertions for the comparator control registers
`timescale 1ns/1ns
`default_nettype none
module cb_regs_checker (
  input wire logic       i_mclk,
  input wire logic       i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       i_pkg48,
  input wire logic       i_cmp_out,
  input wire logic       o_cmp_b_enable,
  input wire logic [1:0] o_pos_hyst_sel,
  input wire logic [1:0] o_neg_hyst_sel,
  input wire logic [2:0] o_inverting_pin_sel,
  input wire logic [2:0] o_noninverting_pin_sel,
  input wire logic [5:0] o_inverting_pin,
  input wire logic       o_inverting_pin_valid,
  input wire logic [5:0] o_noninverting_pin,
  input wire logic       o_noninverting_pin_valid,
  input wire logic [1:0] o_response_mode_sel,
  input wire logic       o_cmp_irq
);
  logic [7:0] wdata_ff;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  // $past on a slice is not portable, so keep last write data here
  always_ff @(posedge i_mclk) wdata_ff <= i_sfr_wdata;
  chk_sel_unused: assert property (
    i_sfr_rd && i_sfr_addr == cb_pkg::ADDR_INPUT_SEL |=> (o_sfr_rdata & 8'h88) == 8'h00)
    else $error("select unused bits set");
  chk_mode_unused: assert property (
    i_sfr_rd && i_sfr_addr == cb_pkg::ADDR_MODE |=> (o_sfr_rdata & 8'hCC) == 8'h00)
    else $error("mode unused bits set");
  chk_mode_write: assert property (
    i_sfr_wr && i_sfr_addr == cb_pkg::ADDR_MODE |=> o_response_mode_sel == wdata_ff[1:0])
    else $error("response mode not loaded");
  chk_hyst_write: assert property (
    i_sfr_wr && i_sfr_addr == cb_pkg::ADDR_CONTROL |=> {o_cmp_b_enable, o_pos_hyst_sel, o_neg_hyst_sel}
      == {wdata_ff[7], wdata_ff[3:0]})
    else $error("control fields not loaded");
  chk_sel_write: assert property (
    i_sfr_wr && i_sfr_addr == cb_pkg::ADDR_INPUT_SEL |=> {o_inverting_pin_sel, o_noninverting_pin_sel}
      == {wdata_ff[6:4], wdata_ff[2:0]})
    else $error("pin selects not loaded");
  chk_pin_valid: assert property (
    !$past(i_reset) |-> o_inverting_pin_valid == ($past(o_inverting_pin_sel) <= cb_pkg::SEL_MAX_CODE)
      && o_noninverting_pin_valid == ($past(o_noninverting_pin_sel) <= cb_pkg::SEL_MAX_CODE))
    else $error("pin valid wrong");
  chk_irq_cause: assert property (
    $rose(o_cmp_irq) |-> $past(i_sfr_wr) || $past(i_cmp_out, 3) != $past(i_cmp_out, 4))
    else $error("irq rose without cause");
  chk_irq_holds: assert property (
    o_cmp_irq && !i_sfr_wr |=> o_cmp_irq)
    else $error("irq dropped without write");
  cover property ($rose(o_cmp_irq));
  cover property (i_sfr_wr && i_sfr_addr == cb_pkg::ADDR_MODE);
  cover property (!o_inverting_pin_valid);
endmodule
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench for the comparator control registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic       i_mclk = 1'b0, i_reset = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_pkg48 = 1'b0;
  logic       cmp_level = 1'b0, i_cmp_out, o_cmp_b_enable, o_cmp_irq;
  logic       o_inverting_pin_valid, o_noninverting_pin_valid;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
  logic [1:0] o_pos_hyst_sel, o_neg_hyst_sel, o_response_mode_sel;
  logic [2:0] o_inverting_pin_sel, o_noninverting_pin_sel;
  logic [5:0] o_inverting_pin, o_noninverting_pin;
  int         n_mismatch = 0, tests_run = 0;
  // index is package * 5 + code, entries are {port, bit}
  logic [5:0] neg_tbl [10] = '{6'h0B, 6'h0F, 6'h13, 6'h17, 6'h05, 6'h13, 6'h19, 6'h20, 6'h26, 6'h0A};
  logic [5:0] pos_tbl [10] = '{6'h0A, 6'h0E, 6'h12, 6'h16, 6'h04, 6'h12, 6'h18, 6'h1F, 6'h25, 6'h09};
  cb_regs i_dut (.*);
  cb_cmp_model i_model (.i_enable(o_cmp_b_enable), .i_level(cmp_level), .o_cmp_out(i_cmp_out));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_sfr_wr    <= 1'b1;
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    @(posedge i_mclk);
    i_sfr_wr    <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge i_mclk);
    i_sfr_rd   <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_mclk);
    i_sfr_rd   <= 1'b0;
    @(negedge i_mclk);
    chk(name, exp, o_sfr_rdata);
  endtask
  // bounded wait; a hang ends the run
  task automatic wait_irq(input logic exp);
    int k;
    for (k = 0; k < 8 && o_cmp_irq !== exp; k++) @(negedge i_mclk);
    chk("irq", 8'(exp), 8'(o_cmp_irq));
    // only a real miss ends the run early; a late match on the last try is a pass
    if (o_cmp_irq !== exp) print_verdict();
  endtask
  task automatic set_level(input logic v);
    @(posedge i_mclk);
    cmp_level <= v;
  endtask
  task automatic t_reset;
    rd(cb_pkg::ADDR_CONTROL, 8'h00, "control");
    rd(cb_pkg::ADDR_MODE, 8'h02, "mode");
    rd(cb_pkg::ADDR_INPUT_SEL, 8'h00, "select");
    rd(8'h9B, 8'h00, "unmapped");
    chk("neg pin reset", 8'(neg_tbl[0]), 8'(o_inverting_pin));
    chk("pos pin reset", 8'(pos_tbl[0]), 8'(o_noninverting_pin));
    $display("test reset done");
  endtask
  task automatic t_select;
    wr(cb_pkg::ADDR_INPUT_SEL, 8'hFF);
    rd(cb_pkg::ADDR_INPUT_SEL, 8'h77, "select");
    chk("valid", 8'h00, 8'({o_inverting_pin_valid, o_noninverting_pin_valid}));
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 5; c++) begin
        @(posedge i_mclk);
        i_pkg48 <= p[0];
        wr(cb_pkg::ADDR_INPUT_SEL, 8'((c << 4) | (4 - c)));
        @(negedge i_mclk);
        chk("neg pin", 8'(neg_tbl[p * 5 + c]), 8'(o_inverting_pin));
        chk("pos pin", 8'(pos_tbl[p * 5 + 4 - c]), 8'(o_noninverting_pin));
        chk("valid", 8'h03, 8'({o_inverting_pin_valid, o_noninverting_pin_valid}));
      end
    end
    $display("test select done");
  endtask
  task automatic t_mode;
    wr(cb_pkg::ADDR_MODE, 8'hFF);
    rd(cb_pkg::ADDR_MODE, 8'h33, "mode");
    for (int m = 0; m < 4; m++) begin
      wr(cb_pkg::ADDR_MODE, 8'(m));
      chk("response", 8'(m), 8'(o_response_mode_sel));
      wr(cb_pkg::ADDR_CONTROL, 8'((m << 2) | (3 - m)));
      chk("hyst", 8'((m << 2) | (3 - m)), 8'({o_pos_hyst_sel, o_neg_hyst_sel}));
    end
    $display("test mode done");
  endtask
  task automatic t_edges;
    wr(cb_pkg::ADDR_MODE, 8'h30);
    wr(cb_pkg::ADDR_CONTROL, 8'h80);
    set_level(1'b1);
    wait_irq(1'b1);
    rd(cb_pkg::ADDR_CONTROL, 8'hE0, "rise flag");
    wr(cb_pkg::ADDR_CONTROL, 8'h80);
    wait_irq(1'b0);
    set_level(1'b0);
    wait_irq(1'b1);
    wr(cb_pkg::ADDR_MODE, 8'h20);
    wait_irq(1'b0);
    rd(cb_pkg::ADDR_CONTROL, 8'h90, "fall flag");
    wr(cb_pkg::ADDR_CONTROL, 8'h80);
    wr(cb_pkg::ADDR_MODE, 8'h10);
    set_level(1'b1);
    repeat (6) @(negedge i_mclk);
    chk("masked irq", 8'h00, 8'(o_cmp_irq));
    wr(cb_pkg::ADDR_MODE, 8'h30);
    wait_irq(1'b1);
    wr(cb_pkg::ADDR_CONTROL, 8'h80);
    wait_irq(1'b0);
    $display("test edges done");
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_reset();
    t_select();
    t_mode();
    t_edges();
    print_verdict();
  end
endmodule
bind cb_regs cb_regs_checker i_chk (.*);
`default_nettype wire
